// >>> design/acs_regs.svh
// constants and timing counts for the conversion sequencer
// What this block does
// - each conversion yields one 10-bit result
// - converter clock divided down from peripheral clock
// - sampling interval 2, 4, 6 or 8 periods
// - sample phase lasts three sampling intervals
// - conversion phase lasts 13 converter periods
// - range select; out-of-range inputs saturate
// - regulator enable and ready; wait for ready
// - interrupt after each single/continuous conversion or accumulate set when enabled
// - mux picks six pins, temperature, voltage
// - arm sets source and mode, no start
// - single-shot does one conversion then idles
// - pollable completion status for conversion or set
// - continuous and accumulate restart back to back
// - continuous repeats until stop command
// - continuous result holds until next completes
// - accumulate runs 2/4/8/16 conversions, sums, stops
// - accumulate ignores armed single/continuous mode
// - accumulate flags only after all conversions
// - accumulate result is raw sum, undivided
// - stop aborts accumulation anytime, returns idle
// - converter alone drives analogue interrupt line
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_PCLK_HZ      10_000_000
`define ACS_CONV_PERIODS 13
`define ACS_SEL_MAX      3'h7
`define ACS_DIV_RESET    8'h0A
`endif

// >>> design/acs_pkg.sv
// types shared by the conversion sequencer
package acs_pkg;
  typedef enum logic [1:0] {ACS_MODE_SINGLE, ACS_MODE_CONT} acs_mode_e;
  typedef struct packed {
    logic [2:0] src;
    logic       range2x;
    logic       cont;
  } acs_arm_s;
  typedef struct packed {
    logic [15:0] value;
    logic        accum;
  } acs_result_s;
endpackage : acs_pkg

// >>> design/acs_fifo.sv
// result fifo with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module acs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  // refuse depths the pointer wrap bit cannot serve, at elaboration
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full_w;
  logic             empty_w;
  assign full_w      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty_w     = (wr_q == rd_q);
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  // write pointer and storage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
    end else if (in_valid_i && !full_w) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
      wr_q                <= wr_q + 1'b1;
    end
  end
  // read pointer
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (out_ready_i && !empty_w) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : acs_fifo
`default_nettype wire

// >>> design/acs_sequencer.sv
// converter control: clock divider, sample/convert phases, modes
`timescale 1ns/1ps
`default_nettype none
`include "acs_regs.svh"
module acs_sequencer import acs_pkg::*; #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // analogue setup
  input  wire logic [7:0]        clk_div_i,
  input  wire logic [1:0]        sample_sel_i,
  input  wire logic              irq_enable_i,
  input  wire logic              reg_enable_i,
  output logic                   reg_enable_o,
  input  wire logic              reg_ready_i,
  output logic                   regulator_ready_o,
  // commands, one-cycle pulses
  input  wire logic              converter_arm_command_i,
  input  wire acs_arm_s          arm_cfg_i,
  input  wire logic              conversion_start_command_i,
  input  wire logic              accumulate_start_command_i,
  input  wire logic [1:0]        accum_count_sel_i,
  input  wire logic              converter_stop_command_i,
  // converter core
  output logic [2:0]             mux_sel_o,
  output logic                   range2x_o,
  output logic                   sample_o,
  output logic                   convert_o,
  input  wire logic [9:0]        core_data_i,
  input  wire logic              core_over_i,
  // status and result
  output logic                   completion_poll_o,
  output logic                   busy_o,
  output logic [15:0]            result_read_o,
  output logic                   analogue_irq_source_o,
  output logic                   adc_clk_en_o,
  // result stream
  output logic                   res_valid_o,
  input  wire logic              res_ready_i,
  output acs_result_s            res_data_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acs_state_e;

  // two-flop sync for regulator ready and core saturation flag (pins)
  logic [1:0] rdy_sync_q;
  logic [1:0] ovr_sync_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdy_sync_q <= 2'h0;
      ovr_sync_q <= 2'h0;
    end else begin
      rdy_sync_q <= {rdy_sync_q[0], reg_ready_i};
      ovr_sync_q <= {ovr_sync_q[0], core_over_i};
    end
  end
  assign regulator_ready_o = rdy_sync_q[1];
  assign reg_enable_o      = reg_enable_i;

  // converter clock as enable pulse; a zero divider is treated as one
  logic [7:0] div_q;
  logic       tick_w;
  assign tick_w       = (div_q == 8'h00);
  assign adc_clk_en_o = tick_w;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick_w) begin
      div_q <= (clk_div_i == 8'h00) ? 8'h00 : clk_div_i - 8'h01;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // armed configuration latched only by the arm command
  acs_arm_s arm_q;
  logic     armed_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      arm_q   <= '0;
      armed_q <= 1'b0;
    end else if (converter_stop_command_i) begin
      armed_q <= 1'b0;
    end else if (converter_arm_command_i) begin
      arm_q   <= arm_cfg_i;
      armed_q <= 1'b1;
    end
  end
  assign mux_sel_o = (arm_q.src > `ACS_SEL_MAX) ? `ACS_SEL_MAX : arm_q.src;
  assign range2x_o = arm_q.range2x;

  // phase lengths in converter periods
  logic [4:0] samp_len_w;
  always_comb begin
    samp_len_w = 5'((5'(sample_sel_i) + 5'd1) * 5'd6);
  end

  // sequencer state
  acs_state_e  st_q;
  logic [4:0]  ph_cnt_q;
  logic        accum_q;
  logic        cont_q;
  logic [4:0]  remain_q;
  logic        conv_done_w;
  logic        start_ok_w;
  assign start_ok_w  = armed_q && regulator_ready_o && st_q == ST_IDLE;
  assign conv_done_w = tick_w && st_q == ST_CONVERT
                       && ph_cnt_q == 5'(`ACS_CONV_PERIODS - 1);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || converter_stop_command_i) begin
      st_q     <= ST_IDLE;
      ph_cnt_q <= 5'd0;
      accum_q  <= 1'b0;
      cont_q   <= 1'b0;
      remain_q <= 5'd0;
    end else if (start_ok_w && accumulate_start_command_i) begin
      st_q     <= ST_SAMPLE;
      ph_cnt_q <= 5'd0;
      accum_q  <= 1'b1;
      cont_q   <= 1'b0;
      remain_q <= 5'(5'd2 << accum_count_sel_i);
    end else if (start_ok_w && conversion_start_command_i) begin
      st_q     <= ST_SAMPLE;
      ph_cnt_q <= 5'd0;
      accum_q  <= 1'b0;
      cont_q   <= arm_q.cont;
      remain_q <= 5'd1;
    end else if (tick_w) begin
      unique case (st_q)
        ST_IDLE: begin
          ph_cnt_q <= 5'd0;
        end
        ST_SAMPLE: begin
          if (ph_cnt_q == samp_len_w - 5'd1) begin
            st_q     <= ST_CONVERT;
            ph_cnt_q <= 5'd0;
          end else begin
            ph_cnt_q <= ph_cnt_q + 5'd1;
          end
        end
        ST_CONVERT: begin
          if (ph_cnt_q == 5'(`ACS_CONV_PERIODS - 1)) begin
            ph_cnt_q <= 5'd0;
            if (cont_q || (accum_q && remain_q != 5'd1)) begin
              st_q <= ST_SAMPLE;
            end else begin
              st_q <= ST_IDLE;
            end
            if (accum_q) begin
              remain_q <= remain_q - 5'd1;
            end
          end else begin
            ph_cnt_q <= ph_cnt_q + 5'd1;
          end
        end
      endcase
    end
  end
  assign sample_o  = (st_q == ST_SAMPLE);
  assign convert_o = (st_q == ST_CONVERT);
  assign busy_o    = (st_q != ST_IDLE);

  // saturate on out-of-range, then accumulate raw sum
  logic [9:0]  sample_w;
  logic [15:0] acc_q;
  logic        set_done_w;
  assign sample_w   = ovr_sync_q[1] ? 10'h3FF : core_data_i;
  assign set_done_w = conv_done_w && (!accum_q || remain_q == 5'd1);
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || (start_ok_w && accumulate_start_command_i)) begin
      acc_q <= 16'h0000;
    end else if (conv_done_w && accum_q) begin
      acc_q <= acc_q + {6'h00, sample_w};
    end
  end

  // result register, updates only when a conversion or set completes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      result_read_o <= 16'h0000;
    end else if (set_done_w) begin
      result_read_o <= accum_q ? acc_q + {6'h00, sample_w}
                               : {6'h00, sample_w};
    end
  end

  // completion flag: set wins over clear by a new start
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      completion_poll_o <= 1'b0;
    end else if (set_done_w) begin
      completion_poll_o <= 1'b1;
    end else if (start_ok_w && (conversion_start_command_i || accumulate_start_command_i)) begin
      completion_poll_o <= 1'b0;
    end
  end

  // interrupt pulse, sole source of the analogue line
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      analogue_irq_source_o <= 1'b0;
    end else begin
      analogue_irq_source_o <= set_done_w && irq_enable_i;
    end
  end

  // result stream; a full fifo drops the word, register still holds it
  logic        fifo_in_ready_w;
  acs_result_s fifo_in_w;
  assign fifo_in_w.value = accum_q ? acc_q + {6'h00, sample_w} : {6'h00, sample_w};
  assign fifo_in_w.accum = accum_q;
  acs_fifo #(
    .WIDTH ($bits(acs_result_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (set_done_w),
    .in_ready_o  (fifo_in_ready_w),
    .in_data_i   (fifo_in_w),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );
  logic unused_w;
  assign unused_w = fifo_in_ready_w;

  // checks
  sequence s_conv_end;
    conv_done_w && !accum_q;
  endsequence
  property p_irq_after_done;
    @(posedge ref_clk_i) disable iff (rst_i)
      (set_done_w && irq_enable_i) |=> analogue_irq_source_o;
  endproperty
  a_irq_after_done: assert property (p_irq_after_done) else $error("irq missing");
  property p_irq_cause;
    @(posedge ref_clk_i) disable iff (rst_i)
      analogue_irq_source_o |-> $past(set_done_w);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("spurious irq");
  property p_single_idle;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_conv_end ##0 !cont_q && !converter_stop_command_i) |=> st_q == ST_IDLE;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("single not idle");
  property p_cont_again;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s_conv_end ##0 cont_q && !converter_stop_command_i) |=> st_q == ST_SAMPLE;
  endproperty
  a_cont_again: assert property (p_cont_again) else $error("no restart");
  property p_stop_idle;
    @(posedge ref_clk_i) disable iff (rst_i)
      converter_stop_command_i |=> st_q == ST_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop ignored");
  property p_result_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      !set_done_w |=> $stable(result_read_o);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");
  property p_accum_flag;
    @(posedge ref_clk_i) disable iff (rst_i)
      (conv_done_w && accum_q && remain_q != 5'd1) |=> !$rose(completion_poll_o);
  endproperty
  a_accum_flag: assert property (p_accum_flag) else $error("early done");
  property p_conv_len;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(convert_o) |-> convert_o [*8];
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("short convert");
  property p_no_start_unarmed;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!armed_q && st_q == ST_IDLE && !converter_arm_command_i) |=> st_q == ST_IDLE;
  endproperty
  a_no_start_unarmed: assert property (p_no_start_unarmed) else $error("ran unarmed");
  // an accepted start must leave idle for the sample phase at once
  sequence s_start_taken;
    start_ok_w && conversion_start_command_i && !converter_stop_command_i;
  endsequence
  property p_start_sample;
    @(posedge ref_clk_i) disable iff (rst_i)
      s_start_taken |=> sample_o;
  endproperty
  a_start_sample: assert property (p_start_sample) else $error("start lost");
  // accumulate start loads the selected conversion count
  property p_accum_count;
    @(posedge ref_clk_i) disable iff (rst_i)
      (start_ok_w && accumulate_start_command_i && !converter_stop_command_i)
        |=> (accum_q && remain_q == 5'(5'd2 << $past(accum_count_sel_i)));
  endproperty
  a_accum_count: assert property (p_accum_count) else $error("bad accumulate count");
  // a finished conversion or set always raises the poll flag
  property p_done_poll;
    @(posedge ref_clk_i) disable iff (rst_i)
      set_done_w |=> completion_poll_o;
  endproperty
  a_done_poll: assert property (p_done_poll) else $error("poll not set");
  // last sample tick hands over to the convert phase
  property p_sample_end;
    @(posedge ref_clk_i) disable iff (rst_i)
      (st_q == ST_SAMPLE && tick_w && ph_cnt_q == samp_len_w - 5'd1
       && !converter_stop_command_i) |=> convert_o;
  endproperty
  a_sample_end: assert property (p_sample_end) else $error("no convert phase");
endmodule : acs_sequencer
`default_nettype wire

// >>> verif/acs_core_model.sv
// behavioural model of the input multiplexer and converter core
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  // clock
  input  wire logic       ref_clk_i,
  // phase controls from the sequencer
  input  wire logic [2:0] mux_sel_i,
  input  wire logic       sample_i,
  input  wire logic       convert_i,
  input  wire logic       over_req_i,
  // data back to the sequencer
  output logic      [9:0] core_data_o,
  output logic            core_over_o,
  output logic      [6:0] conv_cnt_o
);
  logic [9:0] held_q = 10'h000;
  logic [6:0] cnt_q  = 7'h00;
  logic       conv_q = 1'b0;
  // capture source and a running count so each result is distinct
  always @(posedge ref_clk_i) begin
    conv_q <= convert_i;
    if (sample_i) held_q <= {mux_sel_i, cnt_q};
    if (conv_q && !convert_i) cnt_q <= cnt_q + 7'h01;
  end
  // data is only valid in the convert phase; elsewhere show garbage
  assign core_data_o = convert_i ? held_q : ~held_q;
  assign core_over_o = over_req_i & (sample_i | convert_i);
  assign conv_cnt_o  = cnt_q;
endmodule : acs_core_model
`default_nettype wire

// >>> verif/adc_conversion_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t %s", $time, m); end end
module adc_conversion_sequencer_bench import acs_pkg::*;;
  logic        ref_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  div       = 8'h01;
  logic [1:0]  ssel      = 2'h0;
  logic [1:0]  asel      = 2'h0;
  logic        irq_en    = 1'b1;
  logic        rdy       = 1'b0;
  logic        arm = 1'b0, start = 1'b0, acc = 1'b0, stop = 1'b0, over = 1'b0;
  logic        rrdy      = 1'b1;
  logic        regon     = 1'b0;
  acs_arm_s    cfg       = '0;
  logic [2:0]  mux;
  logic        r2x, smp, cnv, poll, busy, irq, cen, rvalid, regen_o, rdy_o, cnv_d, cov;
  logic [9:0]  cdata;
  logic [6:0]  kcnt, k0;
  logic [15:0] result, exp;
  acs_result_s rdata;
  int mismatches = 0, compares = 0, samp_n, conv_n, irq_n, ends_n, en_n, gap_n, g1;
  int s, i, n, words;

  acs_sequencer acs_sequencer_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_div_i(div),
    .sample_sel_i(ssel), .irq_enable_i(irq_en), .reg_enable_i(regon), .reg_enable_o(regen_o),
    .reg_ready_i(rdy), .regulator_ready_o(rdy_o), .converter_arm_command_i(arm),
    .arm_cfg_i(cfg), .conversion_start_command_i(start), .accumulate_start_command_i(acc),
    .accum_count_sel_i(asel), .converter_stop_command_i(stop), .mux_sel_o(mux),
    .range2x_o(r2x), .sample_o(smp), .convert_o(cnv), .core_data_i(cdata),
    .core_over_i(cov), .completion_poll_o(poll), .busy_o(busy), .result_read_o(result),
    .analogue_irq_source_o(irq), .adc_clk_en_o(cen), .res_valid_o(rvalid),
    .res_ready_i(rrdy), .res_data_o(rdata));
  acs_core_model acs_core_model_i (.ref_clk_i(ref_clk_i), .mux_sel_i(mux), .sample_i(smp),
    .convert_i(cnv), .over_req_i(over), .core_data_o(cdata), .core_over_o(cov),
    .conv_cnt_o(kcnt));

  always #50 ref_clk_i = ~ref_clk_i;
  // tally phase lengths and events; gaps show lost cycles between conversions
  always @(posedge ref_clk_i) begin
    samp_n += smp;
    conv_n += cnv;
    irq_n += irq;
    en_n += cen;
    gap_n += (!smp && !cnv);
    ends_n += (cnv_d && !cnv);
    cnv_d <= cnv;
  end

  task automatic tick(input int c);
    repeat (c) @(negedge ref_clk_i);
  endtask : tick
  // one-cycle command pulse: {arm, start, accumulate, stop}
  task automatic send(input logic [3:0] m);
    {arm, start, acc, stop} = m;
    tick(1);
    {arm, start, acc, stop} = 4'h0;
  endtask : send
  task automatic clear();
    {samp_n, conv_n, irq_n, ends_n, en_n, gap_n} = '0;
    k0 = kcnt;
  endtask : clear
  // bounded wait for a number of finished conversions
  task automatic wait_ends(input int c);
    for (int j = 0; j < 5000 && ends_n < c; j++) tick(1);
    if (ends_n < c) begin
      mismatches++;
      $display("[FAIL] %0t wait timed out", $time);
      test_done();
    end else tick(2);
  endtask : wait_ends
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    tick(2);
    rst_i = 1'b0;
    `CHK(poll, 1'b0, "poll after reset")
    `CHK(regen_o, 1'b0, "regulator off")
    regon = 1'b1;
    tick(1);
    `CHK(regen_o, 1'b1, "regulator on")
    // arm without regulator ready, then ready but no start
    cfg = '{3'h5, 1'b1, 1'b0};
    send(4'b1000);
    send(4'b0100);
    tick(4);
    `CHK(busy, 1'b0, "start taken before ready")
    rdy = 1'b1;
    tick(10);
    `CHK(rdy_o, 1'b1, "regulator ready")
    `CHK(busy, 1'b0, "arm started a conversion")
    `CHK({mux, r2x}, 4'hb, "armed source and range")
    $display("test arm done");
    // single shot on every source and every sampling interval
    for (s = 0; s < 8; s++) begin
      irq_en = s[0];
      ssel = s[1:0];
      cfg = '{s[2:0], 1'b0, 1'b0};
      send(4'b1000);
      clear();
      exp = {6'h00, s[2:0], k0};
      send(4'b0100);
      wait_ends(1);
      tick(20);
      `CHK(samp_n, 6 * (s % 4 + 1), "sample length")
      `CHK(conv_n, 13, "convert length")
      `CHK(ends_n, 1, "single shot count")
      `CHK({busy, poll}, 2'b01, "single shot idle and done")
      `CHK(irq_n, s % 2, "interrupt per conversion")
      `CHK(result, exp, "single result")
    end
    $display("test single done");
    // input beyond range saturates
    irq_en = 1'b1;
    over = 1'b1;
    cfg = '{3'h1, 1'b1, 1'b0};
    send(4'b1000);
    clear();
    send(4'b0100);
    wait_ends(1);
    `CHK({r2x, result}, {1'b1, 16'h03ff}, "saturated result")
    over = 1'b0;
    $display("test saturate done");
    // continuous with the result stream stalled
    rrdy = 1'b0;
    cfg = '{3'h3, 1'b0, 1'b1};
    send(4'b1000);
    clear();
    exp = {6'h00, 3'h3, k0};
    send(4'b0100);
    wait_ends(1);
    g1 = gap_n;
    tick(15);
    `CHK(result, exp, "result held")
    wait_ends(18);
    `CHK(busy, 1'b1, "continuous still running")
    `CHK(gap_n, g1, "gap between conversions")
    send(4'b0001);
    tick(3);
    `CHK(busy, 1'b0, "stop ends continuous")
    rrdy = 1'b1;
    words = 0;
    for (i = 0; i < 40; i++) begin
      if (rvalid === 1'b1) begin
        if (words == 0) `CHK(rdata, {exp, 1'b0}, "first stream word")
        words++;
      end
      tick(1);
    end
    `CHK(words, 16, "stream buffer depth")
    $display("test continuous done");
    // accumulate every count with continuous armed
    for (s = 0; s < 4; s++) begin
      cfg = '{3'h6, 1'b0, 1'b1};
      send(4'b1000);
      asel = s[1:0];
      n = 2 << s;
      clear();
      exp = 16'h0000;
      for (i = 0; i < n; i++) exp += {6'h00, 3'h6, 7'(k0 + i)};
      send(4'b0010);
      wait_ends(1);
      `CHK(poll, 1'b0, "early completion")
      wait_ends(n);
      tick(20);
      `CHK(ends_n, n, "accumulate count")
      `CHK({busy, poll}, 2'b01, "accumulate done")
      `CHK(irq_n, 1, "one interrupt per set")
      `CHK(result, exp, "raw sum")
    end
    $display("test accumulate done");
    // stop in the middle of an accumulation
    send(4'b1000);
    asel = 2'h3;
    clear();
    send(4'b0010);
    wait_ends(2);
    send(4'b0001);
    tick(60);
    `CHK({busy, poll}, 2'b00, "abort to idle")
    `CHK(ends_n, 2, "no conversion after abort")
    $display("test abort done");
    // converter clock divided down
    div = 8'h03;
    tick(4);
    clear();
    tick(30);
    `CHK(en_n, 10, "converter clock rate")
    $display("test divider done");
    test_done();
  end
endmodule : adc_conversion_sequencer_bench
`default_nettype wire
